// ===== logic/smcs_pkg.sv
// Package for the stop mode clock sequencer: states, timing counts, carriers.
// Assumes a single 100 MHz clock domain and a synchronous active-high reset.
package smcs_pkg;

  // Clock rate and derived timing
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned QC_OSC_CYCLES    = 4096;   // Oscillator cycles to a passing check
  localparam int unsigned FULL_STOP_WINDOWS = 50;    // Most check windows after full stop
  localparam int unsigned CNT_W            = 16;
  localparam logic [7:0]  WIN_CNT_RESET    = 8'h00;
  localparam logic        FLAG_RESET       = 1'b0;

  // Sequencer states
  typedef enum logic [3:0] {
    SMCS_RUN      = 4'h0,
    SMCS_SWITCH   = 4'h1,
    SMCS_PLL_OFF  = 4'h2,
    SMCS_CORE_OFF = 4'h3,
    SMCS_SYS_OFF  = 4'h4,
    SMCS_PSTOP    = 4'h5,
    SMCS_FSTOP    = 4'h6,
    SMCS_FWAKE    = 4'h7,
    SMCS_RSTGEN   = 4'h8
  } smcs_state_t;

  // Configuration bits from the register space
  typedef struct packed {
    logic pseudoStopSelect;
    logic watchdogStopEnable;
    logic wakeupTimerStopEnable;
    logic clockMonitorEnable;
    logic selfClockEnable;
    logic selfClockIrqEnable;
  } smcs_cfg_t;

  // Clock and power gating outputs
  typedef struct packed {
    logic oscillatorEnable;
    logic pllEnable;
    logic coreClockEnable;
    logic systemClockEnable;
    logic regulatorEnable;
    logic wakeupTimerRun;
    logic watchdogRun;
  } smcs_gate_t;

endpackage

// ===== logic/smcs_quality_checker.sv
// Clock quality checker: counts good oscillator cycles until a pass,
// one check window at a time, and counts windows.
// Assumes oscGood is already synchronised to clk_sys.
`timescale 1ns/1ns
module smcs_quality_checker
  import smcs_pkg::*;
#(
  parameter int unsigned PASS_CYCLES = QC_OSC_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       oscGood,
  // Status
  output logic            busy,
  output logic            pass,
  output logic [7:0]      windows
);
  logic [CNT_W-1:0] count_q;
  logic             busy_q;

  // Count consecutive good cycles; a bad cycle closes the window
  always_ff @(posedge clk_sys) begin
    if (sys_rst || abort) begin
      busy_q  <= 1'b0;
      count_q <= '0;
      pass    <= 1'b0;
      windows <= WIN_CNT_RESET;
    end else begin
      pass <= 1'b0;
      if (start && !busy_q) begin
        busy_q  <= 1'b1;
        count_q <= '0;
        windows <= WIN_CNT_RESET;
      end else if (busy_q) begin
        if (!oscGood) begin
          count_q <= '0;
          if (windows != 8'hFF) windows <= windows + 8'h01;
        end else if (count_q == CNT_W'(PASS_CYCLES - 1)) begin
          busy_q <= 1'b0;
          pass   <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end

  assign busy = busy_q;
endmodule

// ===== logic/smcs_stop_sequencer.sv
// Stop mode clock sequencer: stop entry, pseudo-stop wake-up, clock loss.
// Assumes oscillator status and interrupt lines arrive asynchronously.
//
// Summary of operation
// - Gate clocks by stop bits; oscillator off in full stop
// - Counters freeze, never reinitialised, while stopped
// - Wakeup timer and watchdog run in pseudo-stop when enabled
// - Request regulator power-down on stop entry
// - Clear PLL select first on stop request
// - Disable PLL, core, system clocks, then active
// - Pseudo-stop from self-clock keeps checking, PLL on
// - Full stop aborts check, full check on exit
// - External reset resets config, starts reset generator
// - Monitor loss without self-clock gives monitor reset
// - Loss with irq enabled wakes in self-clock
// - Loss with irq disabled sets flag, no wake
// - Other wakeup exits; PLL select reads cleared
// - Monitor disabled: clock loss ignored
// - Loss, irq off: stay stopped, PLL, regulator on
// - Passing check ends self-clock, PLL, regulator off
// - After recovery, wake or reset on oscillator
// - No recovery: endless checks, exit on self-clock
// - Self-clock flag with irq enabled acts as wakeup
// - Full stop wake runs at most 50 windows
`timescale 1ns/1ns
module smcs_stop_sequencer
  import smcs_pkg::*;
#(
  parameter int unsigned PASS_CYCLES  = QC_OSC_CYCLES,
  parameter int unsigned MAX_WINDOWS  = FULL_STOP_WINDOWS
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Asynchronous pins and sources
  input  wire logic        externalReset,
  input  wire logic        oscGoodPin,
  input  wire logic        wakeupIrqPin,
  // Core request and configuration
  input  wire logic        stopRequest,
  input  wire smcs_cfg_t   cfg,
  input  wire logic        pllSelectSet,
  input  wire logic        selfClockFlagClear,
  // Gating and status
  output smcs_gate_t       gate,
  output logic             stopActive,
  output logic             phaseLoopClockSelect,
  output logic             selfClockMode,
  output logic             selfClockIrqFlag,
  output logic             selfClockIrq,
  output logic             clockMonitorReset,
  output logic             resetGenStart,
  output logic             counterFreeze
);
  smcs_state_t state_q;
  smcs_state_t state_d;
  logic [1:0]  extSync_q;
  logic [1:0]  oscSync_q;
  logic [1:0]  irqSync_q;
  logic        extRst;
  logic        oscGood;
  logic        wakeIrq;
  logic        scm_q;
  logic        flag_q;
  logic        phase_loop_clock_select_q;
  logic        scmNext;
  logic        qcStart;
  logic        qcAbort;
  logic        qcBusy;
  logic        qcPass;
  logic [7:0]  qcWindows;
  logic        lossSeen;
  logic        pseudo;
  logic        fullDone;

  // Decode of the sequencer states, shared by the gating and status logic.
  // Kept in functions so that gates and status can never disagree on a state.

  // True in the two settled stop states
  // (the entry steps and the full-stop wake are not counted here)
  function automatic logic inStop(input smcs_state_t s);
    return s inside {SMCS_PSTOP, SMCS_FSTOP};
  endfunction

  // Stop is held until the clocks are handed back after a full-stop wake;
  // the wake checks run with core and system clocks still gated
  function automatic logic stopHeld(input smcs_state_t s);
    return s inside {SMCS_PSTOP, SMCS_FSTOP, SMCS_FWAKE};
  endfunction

  // Core clock runs until its own step of the entry sequence
  // and comes back only in RUN or the reset generator state
  function automatic logic coreRuns(input smcs_state_t s);
    return s inside {SMCS_RUN, SMCS_SWITCH, SMCS_PLL_OFF, SMCS_RSTGEN};
  endfunction

  // System clocks go last, one step after the core clock, so bus logic
  // can still finish what the core left behind
  function automatic logic systemRuns(input smcs_state_t s);
    return coreRuns(s) || (s == SMCS_CORE_OFF);
  endfunction

  // PLL is wanted by the state only in RUN, SWITCH and RSTGEN; self-clock mode
  // and a running check keep it up everywhere else
  function automatic logic pllRuns(input smcs_state_t s);
    return s inside {SMCS_RUN, SMCS_SWITCH, SMCS_RSTGEN};
  endfunction

  // Periodic timer or watchdog: runs outside stop, and in pseudo-stop only
  // when its stop enable is set; full stop always holds it
  function automatic logic timerRuns(input smcs_state_t s, input logic stopEnable);
    return !stopHeld(s) || (s == SMCS_PSTOP && stopEnable);
  endfunction

  // Two-stage synchronisers for pins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      extSync_q <= 2'h0;
      oscSync_q <= 2'h3;
      irqSync_q <= 2'h0;
    end else begin
      extSync_q <= {extSync_q[0], externalReset};
      oscSync_q <= {oscSync_q[0], oscGoodPin};
      irqSync_q <= {irqSync_q[0], wakeupIrqPin};
    end
  end
  assign extRst  = extSync_q[1];
  assign oscGood = oscSync_q[1];
  assign wakeIrq = irqSync_q[1];

  // Loss is only seen with the monitor on, and never in full stop
  assign lossSeen = cfg.clockMonitorEnable && !oscGood && state_q != SMCS_FSTOP;
  assign pseudo   = cfg.pseudoStopSelect;

  // Full-stop wake ends on a pass or when the window budget is spent
  assign fullDone = qcPass || (qcWindows >= 8'(MAX_WINDOWS));

  // Entry walks SWITCH, PLL_OFF, CORE_OFF and SYS_OFF one edge each, so the
  // PLL select is cleared on the edge that gates the PLL and the core never runs
  // on a PLL that is about to stop. In pseudo-stop the exits are taken in a
  // fixed priority: external reset, monitor reset, wake-up interrupt, then
  // the self-clock flag. A stop request is only looked at in RUN; while a
  // wake or reset sequence is under way it waits, as the core holds it as a
  // level. Full stop has no monitor, so a clock loss there is never acted
  // on; the wake from it re-checks the clock for a bounded number of windows
  // and gives up when the budget is spent, so a dead oscillator cannot keep
  // the device asleep for ever.
  // Next-state decision
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SMCS_RUN: begin
        if (stopRequest) begin
          state_d = SMCS_SWITCH;
        end
      end
      SMCS_SWITCH:   state_d = SMCS_PLL_OFF;
      SMCS_PLL_OFF:  state_d = SMCS_CORE_OFF;
      SMCS_CORE_OFF: state_d = SMCS_SYS_OFF;
      SMCS_SYS_OFF:  state_d = pseudo ? SMCS_PSTOP : SMCS_FSTOP;
      SMCS_PSTOP: begin
        if (extRst) begin
          state_d = SMCS_RSTGEN;
        end else if (lossSeen && !cfg.selfClockEnable) begin
          state_d = SMCS_RSTGEN;
        end else if (wakeIrq) begin
          state_d = SMCS_RUN;
        end else if (flag_q && cfg.selfClockIrqEnable) begin
          state_d = SMCS_RUN;
        end
      end
      SMCS_FSTOP: begin
        if (extRst || wakeIrq) begin
          state_d = SMCS_FWAKE;
        end
      end
      SMCS_FWAKE: begin
        if (fullDone) begin
          state_d = extRst ? SMCS_RSTGEN : SMCS_RUN;
        end
      end
      SMCS_RSTGEN: begin
        if (!extRst) begin
          state_d = SMCS_RUN;
        end
      end
      default: state_d = SMCS_RUN;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= SMCS_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // PLL select: cleared on stop entry, set again only by software
  always_ff @(posedge clk_sys) begin
    if (sys_rst || (extRst && state_q == SMCS_PSTOP)) begin
      phase_loop_clock_select_q <= 1'b0;
    end else if (state_q == SMCS_SWITCH) begin
      phase_loop_clock_select_q <= 1'b0;
    end else if (pllSelectSet && state_q == SMCS_RUN && !stopRequest) begin
      phase_loop_clock_select_q <= 1'b1;
    end
  end

  // Self-clock mode: entered on loss, left on a passing check
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scm_q <= 1'b0;
    end else if (lossSeen && cfg.selfClockEnable) begin
      scm_q <= 1'b1;
    end else if (qcPass) begin
      scm_q <= 1'b0;
    end
  end

  // Self-clock flag: the set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_q <= FLAG_RESET;
    end else if (lossSeen && cfg.selfClockEnable) begin
      flag_q <= 1'b1;
    end else if (selfClockFlagClear) begin
      flag_q <= 1'b0;
    end
  end

  // Next self-clock value, so the gates open on the same edge as the mode
  // rather than one cycle behind it
  always_comb begin
    if (lossSeen && cfg.selfClockEnable) begin
      scmNext = 1'b1;
    end else if (qcPass) begin
      scmNext = 1'b0;
    end else begin
      scmNext = scm_q;
    end
  end

  // Checker control: restart while in self-clock, abort in full stop
  assign qcAbort = (state_q == SMCS_FSTOP);
  assign qcStart = (scm_q && !qcBusy && !qcPass)
                || (lossSeen && cfg.selfClockEnable)
                || (state_q == SMCS_FWAKE && !qcBusy && !fullDone);

  smcs_quality_checker #(
    .PASS_CYCLES (PASS_CYCLES)
  ) u_checker (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (qcStart),
    .abort   (qcAbort),
    .oscGood (oscGood),
    .busy    (qcBusy),
    .pass    (qcPass),
    .windows (qcWindows)
  );

  // Clock and power gating, from the next state so each gate moves on the
  // edge that enters its step. Self-clock uses the next mode for the same
  // reason: PLL and regulator must already be up on the edge the loss is
  // taken, or the self-clock would start from a stopped PLL.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gate <= '{default: 1'b1};
    end else begin
      gate.oscillatorEnable  <= !(state_d == SMCS_FSTOP);
      gate.pllEnable         <= pllRuns(state_d) || scmNext || qcBusy;
      gate.coreClockEnable   <= coreRuns(state_d);
      gate.systemClockEnable <= systemRuns(state_d);
      gate.regulatorEnable   <= !inStop(state_d) || scmNext || qcBusy;
      gate.wakeupTimerRun    <= timerRuns(state_d, cfg.wakeupTimerStopEnable);
      gate.watchdogRun       <= timerRuns(state_d, cfg.watchdogStopEnable);
    end
  end

  // Stop is reported active until the clocks come back, full-stop wake
  // included, so the core never takes a half-woken device for a running one
  // and never raises a new request into the wake sequence
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stopActive <= 1'b0;
    end else begin
      stopActive <= stopHeld(state_d);
    end
  end

  // Monitor reset: loss with self-clock off, in pseudo-stop only. An
  // external reset in the same cycle takes precedence, as in the state
  // decision, so only one reset cause is ever reported
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clockMonitorReset <= 1'b0;
    end else begin
      clockMonitorReset <= state_q == SMCS_PSTOP && lossSeen
                           && !cfg.selfClockEnable && !extRst;
    end
  end

  // One pulse on each entry to the reset generator state; a held external
  // reset does not retrigger it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resetGenStart <= 1'b0;
    end else begin
      resetGenStart <= state_d == SMCS_RSTGEN && state_q != SMCS_RSTGEN;
    end
  end

  // Counters and dividers hold their values through stop and full-stop
  // wake; nothing here clears them, so counting resumes where it stopped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      counterFreeze <= 1'b0;
    end else begin
      counterFreeze <= stopHeld(state_d);
    end
  end

  // Self-clock interrupt level: the flag, gated by its enable; it drops
  // when software clears the flag or its enable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      selfClockIrq <= 1'b0;
    end else begin
      selfClockIrq <= flag_q && cfg.selfClockIrqEnable;
    end
  end

  assign phaseLoopClockSelect = phase_loop_clock_select_q;
  assign selfClockMode        = scm_q;
  assign selfClockIrqFlag     = flag_q;
endmodule

// ===== testbench/smcs_stop_sequencer_properties.sv
// Port checker for the stop sequencer, bound below its endmodule.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module smcs_props
  import smcs_pkg::*;
(
  // Clock, reset and pins
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       externalReset,
  input wire logic       oscGoodPin,
  input wire logic       wakeupIrqPin,
  // Core request and configuration
  input wire logic       stopRequest,
  input wire smcs_cfg_t  cfg,
  // Gating and status
  input wire smcs_gate_t gate,
  input wire logic       stopActive,
  input wire logic       phaseLoopClockSelect,
  input wire logic       clockMonitorReset,
  input wire logic       resetGenStart,
  input wire logic       counterFreeze
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_ENTRY: assert property ($rose(stopActive) |-> $past(stopRequest, 5))
    else $error("stop entry latency wrong");
  AST_PHASE_LOOP_CLOCK_SELECT: assert property ($rose(stopActive) |-> !phaseLoopClockSelect)
    else $error("PLL select not cleared on entry");
  // Core clock stays gated and counters frozen for the whole stop
  AST_GATED: assert property (stopActive |-> !gate.coreClockEnable && counterFreeze)
    else $error("clocks running while stopped");
  AST_OSC: assert property ($rose(stopActive) && !cfg.pseudoStopSelect |-> !gate.oscillatorEnable)
    else $error("oscillator on in full stop");
  AST_CMRST: assert property (stopActive && cfg[5] && cfg[2] && !cfg[1] && !oscGoodPin
    |-> ##[0:4] clockMonitorReset) else $error("no monitor reset on loss");
  // Loss goes unseen with monitoring off; the sequencer must stay put
  AST_NOCM: assert property ($fell(oscGoodPin) && stopActive && !cfg[2]
    |-> ##3 stopActive && !clockMonitorReset) else $error("loss acted on");
  AST_WAKE: assert property (stopActive && cfg[5] && wakeupIrqPin
    |-> ##[1:4] !stopActive && !phaseLoopClockSelect) else $error("pseudo-stop wake late");
  AST_RSTGEN: assert property (stopActive && cfg[5] && $rose(externalReset)
    |-> ##[1:4] resetGenStart) else $error("reset generator not started");
endmodule
bind smcs_stop_sequencer smcs_props smcs_props_i (.clk_sys, .sys_rst, .externalReset,
  .oscGoodPin, .wakeupIrqPin, .stopRequest, .cfg, .gate, .stopActive,
  .phaseLoopClockSelect, .clockMonitorReset, .resetGenStart, .counterFreeze);

// ===== testbench/smcs_core_model.sv
// Core-side model: holds a stop request, then restores PLL select on wake.
// Assumes the bench raises go once per stop and drives it at falling edges.
`timescale 1ns/1ns
module smcs_core_model (
  // Clock
  input wire logic clk_sys,
  // Bench control and device status
  input wire logic go,
  input wire logic stopActive,
  // Requests to the device
  output logic     stopRequest,
  output logic     pllSelectSet
);
  logic go_q = 1'b0;
  logic act_q = 1'b0;
  initial stopRequest = 1'b0;
  initial pllSelectSet = 1'b0;
  // Level held until confirmed, so a slow sequencer never misses it
  always @(negedge clk_sys) begin
    go_q <= go;
    act_q <= stopActive;
    if (stopActive) stopRequest <= 1'b0;
    else if (go && !go_q) stopRequest <= 1'b1;
    pllSelectSet <= act_q && !stopActive;
  end
endmodule

// ===== testbench/tb.sv
// Bench for the stop sequencer: stop configurations, then clock-loss cases.
// Assumes short check counts set by parameter and one 100 MHz clock.
`timescale 1ns/1ns
module tb
  import smcs_pkg::*;
;
  typedef struct packed {smcs_cfg_t c; logic [2:0] e;} smcs_row_t;
  logic clk_sys = 1'b0, sys_rst = 1'b1, go = 1'b0, selfClockFlagClear = 1'b0;
  logic externalReset = 1'b0, oscGoodPin = 1'b1, wakeupIrqPin = 1'b0;
  smcs_cfg_t cfg = '0;
  smcs_gate_t gate;
  logic stopRequest, pllSelectSet, stopActive, phaseLoopClockSelect, selfClockMode;
  logic selfClockIrqFlag, selfClockIrq, clockMonitorReset, resetGenStart, counterFreeze;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  wire [3:0] st = {resetGenStart, clockMonitorReset, selfClockMode, stopActive};
  // Rows: configuration, expected {oscillator, watchdog, wakeup timer}
  smcs_row_t rows [3] = '{'{6'h30, 3'h6}, '{6'h28, 3'h5}, '{6'h18, 3'h0}};
  always #5 clk_sys = ~clk_sys;
  smcs_stop_sequencer #(.PASS_CYCLES(16), .MAX_WINDOWS(3)) smcs_stop_sequencer_i (.clk_sys,
    .sys_rst, .externalReset, .oscGoodPin, .wakeupIrqPin, .stopRequest, .cfg, .pllSelectSet,
    .selfClockFlagClear, .gate, .stopActive, .phaseLoopClockSelect, .selfClockMode,
    .selfClockIrqFlag, .selfClockIrq, .clockMonitorReset, .resetGenStart, .counterFreeze);
  smcs_core_model smcs_core_model_i (.clk_sys, .go, .stopActive, .stopRequest, .pllSelectSet);
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bounded wait at falling edges for one status bit
  task wt(input int i, input logic v);
    for (int k = 0; k < 200 && st[i] !== v; k++) @(negedge clk_sys);
    chk("status", {7'h0, v}, {7'h0, st[i]});
  endtask
  task rst();
    sys_rst <= 1'b1;
    {oscGoodPin, externalReset, wakeupIrqPin} <= 3'h4;
    repeat (3) @(negedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
  endtask
  task stop(input smcs_cfg_t c);
    cfg <= c;
    go <= 1'b1;
    wt(0, 1'b1);
    go <= 1'b0;
  endtask
  task results();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard: the whole run needs under two hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    rst();
    foreach (rows[r]) begin
      stop(rows[r].c);
      chk("gate", {5'h0, rows[r].e}, {5'h0, gate[6], gate[0], gate[1]});
      chk("freeze", 8'h01, {7'h0, counterFreeze});
      wakeupIrqPin <= 1'b1;
      wt(0, 1'b0);
      wakeupIrqPin <= 1'b0;
      chk("phase_loop_clock_select", 8'h00, {7'h0, phaseLoopClockSelect});
      repeat (3) @(negedge clk_sys);
      chk("pllset", 8'h01, {7'h0, phaseLoopClockSelect});
    end
    stop(6'h24);
    oscGoodPin <= 1'b0;
    wt(2, 1'b1);
    rst();
    stop(6'h26);
    oscGoodPin <= 1'b0;
    wt(1, 1'b1);
    chk("loss", 8'h0F, {4'h0, stopActive, selfClockIrqFlag, gate[5], gate[2]});
    oscGoodPin <= 1'b1;
    wt(1, 1'b0);
    chk("pass", 8'h08, {4'h0, stopActive, 1'b0, gate[5], gate[2]});
    selfClockFlagClear <= 1'b1;
    @(negedge clk_sys);
    selfClockFlagClear <= 1'b0;
    chk("flag", 8'h00, {7'h0, selfClockIrqFlag});
    externalReset <= 1'b1;
    wt(3, 1'b1);
    rst();
    stop(6'h27);
    oscGoodPin <= 1'b0;
    wt(0, 1'b0);
    @(negedge clk_sys);
    chk("scm", 8'h03, {6'h0, selfClockMode, selfClockIrq});
    stop(6'h26);
    chk("scmstop", 8'h03, {6'h0, gate[5], gate[2]});
    rst();
    stop(6'h20);
    oscGoodPin <= 1'b0;
    repeat (10) @(negedge clk_sys);
    chk("ignore", 8'h04, {5'h0, stopActive, clockMonitorReset, selfClockIrqFlag});
    results();
  end
endmodule
